// ==== verification/pulse_capture_far.sv ====
`timescale 1ns/100ps
module pulse_capture_far
(
    input  wire logic core_clk,
    output logic      ext_timer_clock_pin,
    output logic      capture_input_pin
);
    initial begin
        ext_timer_clock_pin = 1'h0;
        capture_input_pin   = 1'h0;
    end
    // ========================================
    // pin levels held well above two clocks
    task automatic trig_pulse();
        @(posedge core_clk);
        ext_timer_clock_pin <= 1'h1;
        repeat (4) @(posedge core_clk);
        ext_timer_clock_pin <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask : trig_pulse
    task automatic set_cap(input logic level);
        @(posedge core_clk);
        capture_input_pin <= level;
        repeat (8) @(posedge core_clk);
    endtask : set_cap
endmodule : pulse_capture_far

// ==== verification/pulse_capture_props.sv ====
`timescale 1ns/100ps
module pulse_capture_props
    import pulse_capture_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_timer_clock_pin,
    input wire logic        capture_input_pin,
    input wire logic        timer_out,
    input wire logic        timer_out_en,
    input wire logic        timer_irq
);
    // ========================================
    // shadow of the control byte
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [2:0] wr_reg;
    logic [2:0] wr_next;
    logic       ctl_wr;
    logic       pulse;
    logic       cap;
    logic       act;
    assign ctl_wr = psel && penable && pready && pwrite && paddr == ctrl_offset && pstrb[0];
    assign pulse  = ctl_reg[2:1] == mode_pulse && ctl_reg[4:3] == pin_single;
    assign cap    = ctl_reg[2:1] == mode_capture;
    assign act    = ctl_reg[oc_pos] ^ ctl_reg[pol_pos];
    always_comb begin
        ctl_next = ctl_wr ? pwdata[7:0] : ctl_reg;
        wr_next  = {wr_reg[1:0], ctl_wr};
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctl_reg <= 8'h00;
            wr_reg  <= 3'h0;
        end else begin
            ctl_reg <= ctl_next;
            wr_reg  <= wr_next;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_capture_no_drive: assert property (cap && $past(cap) |-> !timer_out_en)
        else $error("output enabled in capture");
    chk_run_rise_lead: assert property (ctl_wr && pwdata[0] && pwdata[2:1] == mode_pulse
        && pwdata[4:3] == pin_single && timer_out != (pwdata[5] ^ pwdata[6])
        |-> ##[1:2] timer_out == act) else $error("no leading edge");
    chk_match_irq: assert property (pulse && timer_out_en && $past(timer_out) == act
        && timer_out != act && wr_reg == 3'h0 |-> ##[0:2] timer_irq)
        else $error("pulse end without irq");
    chk_ext_trigger: assert property (pulse && timer_out_en && timer_out != act
        && $rose(ext_timer_clock_pin) |-> ##[1:10] timer_out == act)
        else $error("ext pin did not start pulse");
    chk_capture_irq: assert property (cap && ctl_reg[0] && ctl_reg[4:3] == pin_rise
        && $rose(capture_input_pin) |-> ##[1:8] timer_irq) else $error("capture missed");
    chk_capture_off: assert property (cap && ctl_reg[4:3] == pin_single && !timer_irq
        && $rose(capture_input_pin) |=> (!timer_irq) [*8]) else $error("disabled capture");
    cov_pulse: cover property (pulse && timer_out == act);
    cov_capture: cover property (cap && $rose(timer_irq));
    cov_error: cover property (pslverr);
endmodule : pulse_capture_props

bind single_pulse_and_capture_timer pulse_capture_props chk (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_timer_clock_pin(ext_timer_clock_pin), .capture_input_pin(capture_input_pin),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_irq(timer_irq));

// ==== verification/single_pulse_and_capture_timer_tb_top.sv ====
`timescale 1ns/100ps
module single_pulse_and_capture_timer_tb_top
    import pulse_capture_pkg::*;
;
    localparam logic [31:0] pulse_go   = 32'h000001BD;
    localparam logic [31:0] pulse_idle = 32'h000001BC;
    logic        core_clk, reset, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q1;
    logic [3:0]  pstrb;
    logic        pready, pslverr, ext_timer_clock_pin, capture_input_pin;
    logic        timer_out, timer_out_en, timer_irq;
    int          fails, n_compared;
    single_pulse_and_capture_timer DUT (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out(timer_out),
        .ext_timer_clock_pin(ext_timer_clock_pin), .capture_input_pin(capture_input_pin),
        .timer_out_en(timer_out_en), .timer_irq(timer_irq));
    pulse_capture_far far (.core_clk(core_clk), .ext_timer_clock_pin(ext_timer_clock_pin),
        .capture_input_pin(capture_input_pin));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) fails++;
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_out(input logic lvl);
        for (int n = 0; n < 1000 && timer_out !== lvl; n++) @(posedge core_clk);
        chk("timer_out", timer_out, lvl);
    endtask : wait_out
    task automatic t_regs();
        apb(1'h0, ctrl_offset, 32'h0);
        chk("ctrl", q, 32'h0);
        apb(1'h1, cmp_p_offset, 32'hFFFFFFFF);
        apb(1'h0, cmp_p_offset, 32'h0);
        chk("p", q, {24'h0, low_ones});
        apb(1'h0, 12'h014, 32'h0);
        chk("err", e, 1'h1);
        chk("err_data", q, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_pulse();
        apb(1'h1, cmp_p_offset, 32'h1);
        apb(1'h1, cmp_a_offset, 32'h180);
        apb(1'h1, ctrl_offset, pulse_go);
        @(posedge core_clk);
        chk("out_en", timer_out_en, 1'h1);
        chk("lead", timer_out, 1'h1);
        wait_out(1'h0);
        apb(1'h0, ctrl_offset, 32'h0);
        chk("run", q[0], 1'h0);
        apb(1'h0, status_offset, 32'h0);
        chk("flag_a", q[1:0], 2'h1);
        chk("irq", timer_irq, 1'h1);
        apb(1'h0, count_offset, 32'h0);
        chk("held", q, 32'h180);
        apb(1'h1, status_offset, 32'h1);
        chk("irq_clr", timer_irq, 1'h0);
        apb(1'h1, ctrl_offset, pulse_go);
        apb(1'h0, count_offset, 32'h0);
        chk("restart", q < 32'h10, 1'h1);
        apb(1'h1, ctrl_offset, pulse_idle);
        @(posedge core_clk);
        chk("trail", timer_out, 1'h0);
        apb(1'h0, count_offset, 32'h0);
        q1 = q;
        repeat (5) @(posedge core_clk);
        apb(1'h0, count_offset, 32'h0);
        chk("stopped", q, q1);
        apb(1'h0, status_offset, 32'h0);
        chk("no_flag", q, 32'h0);
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_ext();
        apb(1'h1, cmp_a_offset, 32'h40);
        far.trig_pulse();
        wait_out(1'h1);
        wait_out(1'h0);
        apb(1'h0, status_offset, 32'h0);
        chk("ext_flag", q, 32'h1);
        $display("test ext done");
    endtask : t_ext
    task automatic t_cap();
        logic [1:0] pf;
        apb(1'h1, cmp_p_offset, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pf = 2'(i);
            apb(1'h1, ctrl_offset, 32'h2);
            apb(1'h1, status_offset, 32'h3);
            apb(1'h1, cmp_a_offset, 32'h0);
            apb(1'h1, ctrl_offset, {27'h0, pf, 3'h3});
            far.set_cap(1'h1);
            far.set_cap(1'h0);
            chk("cap_en", timer_out_en, 1'h0);
            chk("cap_irq", timer_irq, pf != pin_single);
            apb(1'h0, cmp_a_offset, 32'h0);
            chk("cap_a", q != 32'h0, pf != pin_single);
        end
        apb(1'h0, count_offset, 32'h0);
        q1 = q;
        apb(1'h0, count_offset, 32'h0);
        chk("free_run", q > q1, 1'h1);
        $display("test capture done");
    endtask : t_cap
    task automatic t_wrap();
        apb(1'h1, ctrl_offset, 32'h2);
        apb(1'h1, status_offset, 32'h3);
        apb(1'h1, cmp_p_offset, 32'h1);
        apb(1'h1, ctrl_offset, 32'h1B);
        for (int n = 0; n < 400 && timer_irq !== 1'h1; n++) @(posedge core_clk);
        chk("wrap_irq", timer_irq, 1'h1);
        apb(1'h0, status_offset, 32'h0);
        chk("flag_p", q, 32'h2);
        apb(1'h0, count_offset, 32'h0);
        chk("wrapped", q[15:8], 8'h00);
        $display("test wrap done");
    endtask : t_wrap
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        fails++;
        report_and_stop();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
        pstrb = 4'hF;
        fails = 0;
        n_compared = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        @(posedge core_clk);
        t_regs();
        t_pulse();
        t_ext();
        t_cap();
        t_wrap();
        report_and_stop();
    end
endmodule : single_pulse_and_capture_timer_tb_top

// ==== verilog/pulse_capture_pkg.sv ====
// Notes on behaviour
// - run bit rising edge triggers pulse
// - external clock pin rising edge sets run bit in pulse
// - run rise starts counter and pulse together
// - run bit clear ends the pulse
// - compare A match clears run bit in pulse
// - compare A match raises interrupt in pulse
// - counter zeroed on run rise and on P match
// - pulse mode ignores P, clear select, swap
// - pin field picks edge; 11 disables capture
// - capture counter starts on run rise
// - capture edge copies counter to A, interrupts
// - capture counter free runs until run falls
// - compare P match wraps counter, interrupts
// - P zero lets counter reach maximum
// - pulses under two clocks may be missed
// - A flag rises with capture latch
// - latch three to four clocks after pin edge
// - capture mode drives no output function
// - P compares counter upper eight bits
// - run rise sets output to initial level
package pulse_capture_pkg;
    // ========================================
    // register map
    localparam logic [11:0] ctrl_offset    = 12'h000;
    localparam logic [11:0] cmp_a_offset   = 12'h004;
    localparam logic [11:0] cmp_p_offset   = 12'h008;
    localparam logic [11:0] count_offset   = 12'h00C;
    localparam logic [11:0] status_offset  = 12'h010;
    // ========================================
    // control field positions
    localparam int run_pos      = 0;
    localparam int mode_lo_pos  = 1;
    localparam int pin_lo_pos   = 3;
    localparam int oc_pos       = 5;
    localparam int pol_pos      = 6;
    localparam int cclr_pos     = 7;
    localparam int dpx_pos      = 8;
    localparam int ctrl_width   = 9;
    localparam int flag_a_pos   = 0;
    localparam int flag_p_pos   = 1;
    // ========================================
    // encodings
    localparam logic [1:0] mode_capture = 2'h1;
    localparam logic [1:0] mode_pulse   = 2'h2;
    localparam logic [1:0] pin_rise     = 2'h0;
    localparam logic [1:0] pin_fall     = 2'h1;
    localparam logic [1:0] pin_both     = 2'h2;
    localparam logic [1:0] pin_single   = 2'h3;
    localparam logic [15:0] count_zero  = 16'h0000;
    localparam logic [15:0] count_one   = 16'h0001;
    localparam logic [7:0]  p_zero      = 8'h00;
    localparam logic [7:0]  low_ones    = 8'hFF;
endpackage : pulse_capture_pkg

// ==== verilog/single_pulse_and_capture_timer.sv ====
`timescale 1ns/100ps
module single_pulse_and_capture_timer
    import pulse_capture_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_timer_clock_pin,
    input  wire logic        capture_input_pin,
    output logic             timer_out,
    output logic             timer_out_en,
    output logic             timer_irq
);
    // ========================================
    // pin synchronisers
    logic [2:0] ck_sync_reg;
    logic [2:0] ck_sync_next;
    logic [2:0] pi_sync_reg;
    logic [2:0] pi_sync_next;
    logic       ck_level_reg;
    logic       ck_level_next;
    logic       pi_level_reg;
    logic       pi_level_next;

    always_comb begin
        ck_sync_next  = {ck_sync_reg[1:0], ext_timer_clock_pin};
        pi_sync_next  = {pi_sync_reg[1:0], capture_input_pin};
        ck_level_next = ck_level_reg;
        pi_level_next = pi_level_reg;
        if (ck_sync_reg[1] == ck_sync_reg[2]) begin
            ck_level_next = ck_sync_reg[2];
        end
        if (pi_sync_reg[1] == pi_sync_reg[2]) begin
            pi_level_next = pi_sync_reg[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ck_sync_reg  <= 3'h0;
            pi_sync_reg  <= 3'h0;
            ck_level_reg <= 1'b0;
            pi_level_reg <= 1'b0;
        end else begin
            ck_sync_reg  <= ck_sync_next;
            pi_sync_reg  <= pi_sync_next;
            ck_level_reg <= ck_level_next;
            pi_level_reg <= pi_level_next;
        end
    end

    wire logic ck_rise = ck_level_next & ~ck_level_reg;
    wire logic pi_rise = pi_level_next & ~pi_level_reg;
    wire logic pi_fall = ~pi_level_next & pi_level_reg;

    // ========================================
    // apb decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offs);
        hit = (addr == offs);
    endfunction : hit

    wire logic acc    = psel & penable;
    wire logic wr     = acc & pwrite & pready;
    wire logic mapped = hit(paddr, ctrl_offset) | hit(paddr, cmp_a_offset) |
                        hit(paddr, cmp_p_offset) | hit(paddr, count_offset) |
                        hit(paddr, status_offset);

    // ========================================
    // timer state
    logic [ctrl_width-1:0] ctrl_reg;
    logic [ctrl_width-1:0] ctrl_next;
    logic [15:0]           count_reg;
    logic [15:0]           count_next;
    logic [15:0]           cmp_a_reg;
    logic [15:0]           cmp_a_next;
    logic [7:0]            cmp_p_reg;
    logic [7:0]            cmp_p_next;
    logic [1:0]            flags_reg;
    logic [1:0]            flags_next;
    logic                  run_prev_reg;
    logic                  run_prev_next;
    logic                  out_reg;
    logic                  out_next;
    logic                  out_en_reg;
    logic                  out_en_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    logic                  ready_reg;
    logic                  ready_next;
    logic                  err_reg;
    logic                  err_next;

    wire logic [1:0] mode = ctrl_reg[mode_lo_pos +: 2];
    wire logic [1:0] pins = ctrl_reg[pin_lo_pos +: 2];
    wire logic       run  = ctrl_reg[run_pos];
    wire logic pulse_mode = (mode == mode_pulse) && (pins == pin_single);
    wire logic cap_mode   = (mode == mode_capture);
    wire logic run_rise   = run & ~run_prev_reg;
    wire logic active_lvl = ctrl_reg[oc_pos] ^ ctrl_reg[pol_pos];

    // match on the value the counter holds now
    wire logic a_match = run & ~run_rise & (count_reg == cmp_a_reg);
    // upper bits against P; zero means full 16-bit wrap
    wire logic p_match = run & ~run_rise & (count_reg[7:0] == low_ones) &
                         ((cmp_p_reg == p_zero) ? (count_reg[15:8] == low_ones)
                                                : (count_reg[15:8] == cmp_p_reg - 8'h01));

    logic cap_edge;
    always_comb begin
        cap_edge = 1'b0;
        case (pins)
            pin_rise: cap_edge = pi_rise;
            pin_fall: cap_edge = pi_fall;
            pin_both: cap_edge = pi_rise | pi_fall;
            default:  cap_edge = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_next     = ctrl_reg;
        count_next    = count_reg;
        cmp_a_next    = cmp_a_reg;
        cmp_p_next    = cmp_p_reg;
        flags_next    = flags_reg;
        run_prev_next = run;
        out_next      = out_reg;
        out_en_next   = out_en_reg;
        rdata_next    = 32'h0000_0000;
        ready_next    = 1'b0;
        err_next      = 1'b0;

        // software writes first, hardware events override
        if (wr && hit(paddr, ctrl_offset)) begin
            if (pstrb[0]) begin
                ctrl_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl_next[dpx_pos] = pwdata[dpx_pos];
            end
        end
        if (wr && hit(paddr, cmp_a_offset)) begin
            if (pstrb[0]) begin
                cmp_a_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                cmp_a_next[15:8] = pwdata[15:8];
            end
        end
        if (wr && hit(paddr, cmp_p_offset) && pstrb[0]) begin
            cmp_p_next = pwdata[7:0];
        end
        // write one to clear
        if (wr && hit(paddr, status_offset) && pstrb[0]) begin
            flags_next = flags_reg & ~pwdata[1:0];
        end

        // counter
        if (run_rise) begin
            count_next = count_zero;
        end else if (run) begin
            count_next = count_reg + count_one;
        end

        if (pulse_mode) begin
            if (ck_rise && !run) begin
                ctrl_next[run_pos] = 1'b1;
            end
            if (run_rise) begin
                out_next = active_lvl;
            end
            if (a_match) begin
                count_next             = count_reg;
                ctrl_next[run_pos]     = 1'b0;
                flags_next[flag_a_pos] = 1'b1;
            end
            if (!run) begin
                out_next = ~active_lvl;
            end
            out_en_next = 1'b1;
        end else if (cap_mode) begin
            out_en_next = 1'b0;
            out_next    = 1'b0;
            if (p_match) begin
                count_next             = count_zero;
                flags_next[flag_p_pos] = 1'b1;
            end
            // latched in the same cycle as the filtered edge
            if (run && cap_edge) begin
                cmp_a_next             = count_reg;
                flags_next[flag_a_pos] = 1'b1;
            end
        end else begin
            out_en_next = 1'b0;
            out_next    = 1'b0;
        end

        if (acc && !ready_reg) begin
            ready_next = 1'b1;
            err_next   = ~mapped;
            if (!pwrite) begin
                if (hit(paddr, ctrl_offset)) begin
                    rdata_next[ctrl_width-1:0] = ctrl_reg;
                end
                if (hit(paddr, cmp_a_offset)) begin
                    rdata_next[15:0] = cmp_a_reg;
                end
                if (hit(paddr, cmp_p_offset)) begin
                    rdata_next[7:0] = cmp_p_reg;
                end
                if (hit(paddr, count_offset)) begin
                    rdata_next[15:0] = count_reg;
                end
                if (hit(paddr, status_offset)) begin
                    rdata_next[1:0] = flags_reg;
                end
            end
        end
        irq_next = |flags_next;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg     <= '0;
            count_reg    <= 16'h0000;
            cmp_a_reg    <= 16'h0000;
            cmp_p_reg    <= 8'h00;
            flags_reg    <= 2'h0;
            run_prev_reg <= 1'b0;
            out_reg      <= 1'b0;
            out_en_reg   <= 1'b0;
            irq_reg      <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            ready_reg    <= 1'b0;
            err_reg      <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            count_reg    <= count_next;
            cmp_a_reg    <= cmp_a_next;
            cmp_p_reg    <= cmp_p_next;
            flags_reg    <= flags_next;
            run_prev_reg <= run_prev_next;
            out_reg      <= out_next;
            out_en_reg   <= out_en_next;
            irq_reg      <= irq_next;
            rdata_reg    <= rdata_next;
            ready_reg    <= ready_next;
            err_reg      <= err_next;
        end
    end

    assign prdata       = rdata_reg;
    assign pready       = ready_reg;
    assign pslverr      = err_reg;
    assign timer_out    = out_reg;
    assign timer_out_en = out_en_reg;
    assign timer_irq    = irq_reg;
endmodule : single_pulse_and_capture_timer
